// file: rtl/ivf_defs.svh
// Constants of the input voltage fault policy block.
// Assumes inclusion by bare name from the package and design files.
`ifndef IVF_DEFS_SVH
`define IVF_DEFS_SVH

// ****************************************
// Command codes
// ****************************************
`define IVF_CODE_OV_WARN   8'h57
`define IVF_CODE_UV_WARN   8'h58
`define IVF_CODE_UV_FAULT  8'h59
`define IVF_CODE_POLICY    8'h5A
`define IVF_CODE_OPTIONS   8'hE0

// ****************************************
// Policy byte, option bit and mantissa fields
// ****************************************
`define IVF_RESP_F         7:6
`define IVF_RETRY_F        5:3
`define IVF_DELAY_F        2:0
`define IVF_RESP_IGNORE    2'h0
`define IVF_RESP_DELAYED   2'h1
`define IVF_RESP_DISABLE   2'h2
`define IVF_RESP_LATCH     2'h3
`define IVF_RETRY_NONE     3'h0
`define IVF_RETRY_ONCE     3'h1
`define IVF_RETRY_ENDLESS  3'h7
`define IVF_OPT_RATIO_BIT  0
`define IVF_MANT_F         10:0

// ****************************************
// Reset values and counter constants
// ****************************************
`define IVF_THR_RST        16'h0000
`define IVF_BYTE_RST       8'h00
`define IVF_CNT_ONE        8'h01
`define IVF_CNT_ZERO       8'h00

`endif

// file: rtl/ivf_pkg.sv
// Types shared by the input voltage fault policy block.
// Assumes ivf_defs.svh is on the include path.
`include "ivf_defs.svh"

package ivf_pkg;

  // One-hot policy states
  typedef enum logic [4:0]
  {
    ST_OFF   = 5'b0_0001,
    ST_RUN   = 5'b0_0010,
    ST_DELAY = 5'b0_0100,
    ST_WAIT  = 5'b0_1000,
    ST_LATCH = 5'b1_0000
  } ivf_state_t;

  // Host command as delivered by the management bus front end
  typedef struct packed
  {
    logic        valid;
    logic        write;
    logic [7:0]  code;
    logic [15:0] wdata;
  } ivf_cmd_t;

  // Status seen by the host
  typedef struct packed
  {
    logic ov_warn;
    logic uv_warn;
    logic uv_fault;
    logic ratio_mode;
    logic latched_off;
  } ivf_status_t;

endpackage

// file: rtl/ivf_sync.sv
// Three-stage synchroniser with agreement filter for one pin.
// Assumes the pin is asynchronous to clk_sys_i.
`timescale 1ns/100ps
`default_nettype none

module ivf_sync
(
  // Clock and reset
  input  wire logic clk_sys_i,
  input  wire logic srst_i,
  // Pin and clean level
  input  wire logic pin_i,
  output logic      level_o
);

  logic s1_q;
  logic s2_q;
  logic s3_q;
  logic lvl_d;

  // Only the second and third stages vote; the first may be metastable
  always_comb
  begin
    lvl_d = (s2_q == s3_q) ? s2_q : level_o;
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (srst_i)
    begin
      s1_q    <= 1'b0;
      s2_q    <= 1'b0;
      s3_q    <= 1'b0;
      level_o <= 1'b0;
    end
    else
    begin
      s1_q    <= pin_i;
      s2_q    <= s1_q;
      s3_q    <= s2_q;
      level_o <= lvl_d;
    end
  end

endmodule

`default_nettype wire

// file: rtl/ivf_top.sv
// Input voltage limits and undervoltage fault policy of a managed converter.
// Assumes a bus front end delivering decoded commands, a measured input
// word in the same Linear exponent as the limits, and a time unit tick.
//
// How it works
// - Overvoltage warning limit, 16-bit Linear, code 0x57, read and write.
// - Undervoltage warning limit at 0x58, also the ratio regulation threshold.
// - Ratio regulation acts only when the option bit at 0xE0 is set.
// - Undervoltage fault limit at 0x59 detects the undervoltage fault.
// - Policy 0x5A selector 00: ignore fault, keep running.
// - Selector 01: run for the delay, then retry policy if fault persists.
// - Selector 10: disable output at once, then follow retry field.
// - Selector 11: stay off until cleared, reset, or off-then-on command.
// - Retry 000: no restart, stay off until cleared.
// - Retry 001: one restart, spaced by delay, then latch off.
// - Retry 010: two restarts, same spacing, then latch off.
// - Retry 011 to 110: three to six restarts, then latch off.
// - Retry 111: restart forever until commanded off or other fault.
// - Delay field is a power of two multiplier of the time unit.
`include "ivf_defs.svh"
`timescale 1ns/100ps
`default_nettype none

module ivf_top
(
  // Clock and reset
  input  wire logic               clk_sys_i,
  input  wire logic               srst_i,
  // Command port
  input  wire ivf_pkg::ivf_cmd_t  cmd_i,
  output logic                    rsp_valid_o,
  output logic                    rsp_err_o,
  output logic [15:0]             rsp_rdata_o,
  // Supervision inputs
  input  wire logic [15:0]        vin_meas_i,
  input  wire logic               unit_tick_i,
  input  wire logic               ctrl_pin_i,
  input  wire logic               operation_on_i,
  input  wire logic               clear_faults_i,
  input  wire logic               status_clear_i,
  input  wire logic               other_fault_i,
  // Results
  output logic                    output_en_o,
  output ivf_pkg::ivf_status_t    status_o
);

  // ****************************************
  // Registers
  // ****************************************
  logic [15:0] ov_warn_q, ov_warn_d;
  logic [15:0] uv_warn_q, uv_warn_d;
  logic [15:0] uv_fault_q, uv_fault_d;
  logic [7:0]  policy_q, policy_d;
  logic [7:0]  options_q, options_d;
  logic        rsp_valid_d;
  logic        rsp_err_d;
  logic [15:0] rsp_rdata_d;
  logic        ctrl_lvl;

  ivf_sync ivf_sync_inst
  (
    .clk_sys_i (clk_sys_i),
    .srst_i    (srst_i),
    .pin_i     (ctrl_pin_i),
    .level_o   (ctrl_lvl)
  );

  always_comb
  begin
    ov_warn_d   = ov_warn_q;
    uv_warn_d   = uv_warn_q;
    uv_fault_d  = uv_fault_q;
    policy_d    = policy_q;
    options_d   = options_q;
    rsp_valid_d = cmd_i.valid;
    rsp_err_d   = 1'b0;
    rsp_rdata_d = `IVF_THR_RST;
    if (cmd_i.valid)
    begin
      unique case (cmd_i.code)
        `IVF_CODE_OV_WARN:
        begin
          rsp_rdata_d = ov_warn_q;
          if (cmd_i.write) ov_warn_d = cmd_i.wdata;
        end
        `IVF_CODE_UV_WARN:
        begin
          rsp_rdata_d = uv_warn_q;
          if (cmd_i.write) uv_warn_d = cmd_i.wdata;
        end
        `IVF_CODE_UV_FAULT:
        begin
          rsp_rdata_d = uv_fault_q;
          if (cmd_i.write) uv_fault_d = cmd_i.wdata;
        end
        `IVF_CODE_POLICY:
        begin
          rsp_rdata_d = {8'h00, policy_q};
          if (cmd_i.write) policy_d = cmd_i.wdata[7:0];
        end
        `IVF_CODE_OPTIONS:
        begin
          rsp_rdata_d = {8'h00, options_q};
          if (cmd_i.write) options_d = cmd_i.wdata[7:0];
        end
        default:
        begin
          rsp_err_d = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (srst_i)
    begin
      ov_warn_q   <= `IVF_THR_RST;
      uv_warn_q   <= `IVF_THR_RST;
      uv_fault_q  <= `IVF_THR_RST;
      policy_q    <= `IVF_BYTE_RST;
      options_q   <= `IVF_BYTE_RST;
      rsp_valid_o <= 1'b0;
      rsp_err_o   <= 1'b0;
      rsp_rdata_o <= `IVF_THR_RST;
    end
    else
    begin
      ov_warn_q   <= ov_warn_d;
      uv_warn_q   <= uv_warn_d;
      uv_fault_q  <= uv_fault_d;
      policy_q    <= policy_d;
      options_q   <= options_d;
      rsp_valid_o <= rsp_valid_d;
      rsp_err_o   <= rsp_err_d;
      rsp_rdata_o <= rsp_rdata_d;
    end
  end

  // ****************************************
  // Comparisons and status
  // ****************************************
  // Mantissas only: limits and measurement share one exponent
  logic signed [10:0] vin_m;
  logic               fault_now;
  logic               en_cmd;
  logic               do_clear;
  ivf_pkg::ivf_status_t status_d;
  ivf_pkg::ivf_state_t  state_q, state_d;

  assign vin_m     = $signed(vin_meas_i[`IVF_MANT_F]);
  assign fault_now = vin_m < $signed(uv_fault_q[`IVF_MANT_F]);
  assign en_cmd    = ctrl_lvl & operation_on_i;
  assign do_clear  = clear_faults_i | status_clear_i;

  always_comb
  begin
    status_d.ov_warn     = vin_m > $signed(ov_warn_q[`IVF_MANT_F]);
    status_d.uv_warn     = vin_m < $signed(uv_warn_q[`IVF_MANT_F]);
    // Set wins over clear so a fault in the clearing cycle survives
    status_d.uv_fault    = fault_now | (status_o.uv_fault & ~do_clear);
    status_d.ratio_mode  = options_q[`IVF_OPT_RATIO_BIT] & status_d.uv_warn;
    status_d.latched_off = (state_d == ivf_pkg::ST_LATCH);
  end

  // ****************************************
  // Fault policy state machine
  // ****************************************
  logic [7:0] cnt_q, cnt_d;
  logic [2:0] tries_q, tries_d;
  logic       out_en_d;
  logic [7:0] units;
  logic       delay_done;
  logic [1:0] resp;
  logic [2:0] retry;

  assign resp       = policy_q[`IVF_RESP_F];
  assign retry      = policy_q[`IVF_RETRY_F];
  assign units      = `IVF_CNT_ONE << policy_q[`IVF_DELAY_F];
  assign delay_done = unit_tick_i & (cnt_q == units - `IVF_CNT_ONE);

  always_comb
  begin
    state_d = state_q;
    cnt_d   = unit_tick_i ? cnt_q + `IVF_CNT_ONE : cnt_q;
    tries_d = tries_q;
    unique case (state_q)
      ivf_pkg::ST_OFF:
      begin
        cnt_d = `IVF_CNT_ZERO;
        if (en_cmd) state_d = ivf_pkg::ST_RUN;
      end
      ivf_pkg::ST_RUN:
      begin
        cnt_d   = `IVF_CNT_ZERO;
        tries_d = retry;
        if (!en_cmd) state_d = ivf_pkg::ST_OFF;
        else if (fault_now)
        begin
          unique case (resp)
            `IVF_RESP_IGNORE:  state_d = ivf_pkg::ST_RUN;
            `IVF_RESP_DELAYED: state_d = ivf_pkg::ST_DELAY;
            `IVF_RESP_DISABLE:
              state_d = (retry == `IVF_RETRY_NONE) ? ivf_pkg::ST_LATCH
                                                   : ivf_pkg::ST_WAIT;
            `IVF_RESP_LATCH:   state_d = ivf_pkg::ST_LATCH;
          endcase
        end
      end
      ivf_pkg::ST_DELAY:
      begin
        if (!en_cmd) state_d = ivf_pkg::ST_OFF;
        else if (delay_done)
        begin
          cnt_d = `IVF_CNT_ZERO;
          if (!fault_now) state_d = ivf_pkg::ST_RUN;
          else state_d = (retry == `IVF_RETRY_NONE) ? ivf_pkg::ST_LATCH
                                                    : ivf_pkg::ST_WAIT;
        end
      end
      ivf_pkg::ST_WAIT:
      begin
        if (!en_cmd) state_d = ivf_pkg::ST_OFF;
        else if (other_fault_i) state_d = ivf_pkg::ST_LATCH;
        else if (delay_done)
        begin
          // Restart attempt fails while the input is still low
          cnt_d = `IVF_CNT_ZERO;
          if (!fault_now) state_d = ivf_pkg::ST_RUN;
          else if (retry == `IVF_RETRY_ENDLESS) state_d = ivf_pkg::ST_WAIT;
          else if (tries_q == `IVF_RETRY_ONCE) state_d = ivf_pkg::ST_LATCH;
          else tries_d = tries_q - `IVF_RETRY_ONCE;
        end
      end
      ivf_pkg::ST_LATCH:
      begin
        cnt_d = `IVF_CNT_ZERO;
        if (!en_cmd) state_d = ivf_pkg::ST_OFF;
        else if (do_clear) state_d = ivf_pkg::ST_RUN;
      end
    endcase
    out_en_d = (state_d == ivf_pkg::ST_RUN) | (state_d == ivf_pkg::ST_DELAY);
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (srst_i)
    begin
      state_q     <= ivf_pkg::ST_OFF;
      cnt_q       <= `IVF_CNT_ZERO;
      tries_q     <= `IVF_RETRY_NONE;
      output_en_o <= 1'b0;
      status_o    <= '0;
    end
    else
    begin
      state_q     <= state_d;
      cnt_q       <= cnt_d;
      tries_q     <= tries_d;
      output_en_o <= out_en_d;
      status_o    <= status_d;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  a_ov_write_store: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    cmd_i.valid && cmd_i.write && cmd_i.code == `IVF_CODE_OV_WARN
    |=> ov_warn_q == $past(cmd_i.wdata))
    else $error("overvoltage limit not stored");
  a_uv_read_back: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    cmd_i.valid && !cmd_i.write && cmd_i.code == `IVF_CODE_UV_WARN
    |=> rsp_valid_o && !rsp_err_o && rsp_rdata_o == $past(uv_warn_q))
    else $error("undervoltage warning readback wrong");
  a_ratio_gated: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    status_o.ratio_mode |-> $past(options_q[`IVF_OPT_RATIO_BIT]) && status_o.uv_warn)
    else $error("ratio mode without option");
  a_ignore_stays_on: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    state_q == ivf_pkg::ST_RUN && en_cmd && fault_now && resp == `IVF_RESP_IGNORE
    |=> output_en_o)
    else $error("ignored fault disabled output");
  a_delay_runs_on: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    state_q == ivf_pkg::ST_RUN && en_cmd && fault_now && resp == `IVF_RESP_DELAYED
    |=> output_en_o && state_q == ivf_pkg::ST_DELAY)
    else $error("delayed response stopped output");
  a_disable_at_once: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    state_q == ivf_pkg::ST_RUN && en_cmd && fault_now && resp == `IVF_RESP_DISABLE
    |=> !output_en_o)
    else $error("output not disabled at once");
  a_latch_holds_off: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    state_q == ivf_pkg::ST_LATCH && en_cmd && !do_clear
    |=> state_q == ivf_pkg::ST_LATCH && !output_en_o)
    else $error("latched state left without clear");
  a_no_retry_latch: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    state_q == ivf_pkg::ST_RUN && en_cmd && fault_now
    && resp == `IVF_RESP_DISABLE && retry == `IVF_RETRY_NONE
    |=> state_q == ivf_pkg::ST_LATCH)
    else $error("retry none did not latch");
  a_last_try_latch: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    state_q == ivf_pkg::ST_WAIT && en_cmd && !other_fault_i && delay_done && fault_now
    && tries_q == `IVF_RETRY_ONCE && retry != `IVF_RETRY_ENDLESS
    |=> state_q == ivf_pkg::ST_LATCH)
    else $error("final failed attempt not latched");
  a_endless_waits: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    state_q == ivf_pkg::ST_WAIT && en_cmd && !other_fault_i && fault_now
    && retry == `IVF_RETRY_ENDLESS |=> state_q == ivf_pkg::ST_WAIT)
    else $error("endless retry stopped");
  a_fault_set_wins: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    fault_now && do_clear |=> status_o.uv_fault)
    else $error("fault flag lost on clear");
  a_warn_no_effect: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    state_q == ivf_pkg::ST_RUN && en_cmd && !fault_now |=> output_en_o)
    else $error("warning changed output");

endmodule

`default_nettype wire

// file: tb/ivf_host_model.sv
// Management bus host model: issues one decoded command at a time.
// Assumes the block registers its answer on the same edge that takes the command.
`timescale 1ns/100ps
`default_nettype none

module ivf_host_model
(
  // Clock
  input  wire logic         clk_sys_i,
  // Command and answer
  output var ivf_pkg::ivf_cmd_t cmd_o,
  input  wire logic         rsp_valid_i,
  input  wire logic         rsp_err_i,
  input  wire logic [15:0]  rsp_rdata_i
);
  initial
  begin
    cmd_o = '0;
  end

  // ****************************************
  // One command, answer taken mid-cycle
  // ****************************************
  // Released fields show the inverse, so a stale word never passes for data
  task automatic xfer(input logic wr, input logic [7:0] c, input logic [15:0] d,
                      output logic [15:0] rd, output logic err);
    @(negedge clk_sys_i);
    cmd_o = '{valid: 1'b1, write: wr, code: c, wdata: d};
    @(negedge clk_sys_i);
    rd  = rsp_valid_i ? rsp_rdata_i : 16'hxxxx;
    err = rsp_valid_i ? rsp_err_i : 1'bx;
    cmd_o = '{valid: 1'b0, write: ~wr, code: ~c, wdata: ~d};
  endtask
endmodule
`default_nettype wire

// file: tb/ivf_tb_top.sv
// Self-checking bench of the input voltage fault policy block.
// Assumes ivf_pkg is compiled first; inputs change on the falling edge.
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e, m) begin n_checks++; if ((g) !== (e)) begin n_fail++; \
  $display("MISMATCH t=%0t %s", $time, m); end end

module ivf_tb_top;
  logic                 clk_sys_i;
  logic                 srst_i = 1'b1;
  ivf_pkg::ivf_cmd_t    cmd_i;
  logic                 rsp_valid_o;
  logic                 rsp_err_o;
  logic [15:0]          rsp_rdata_o;
  logic [15:0]          vin_meas_i = 16'h00C8;
  logic                 unit_tick_i = 1'b0;
  logic                 ctrl_pin_i = 1'b1;
  logic                 operation_on_i = 1'b1;
  logic                 clear_faults_i = 1'b0;
  logic                 status_clear_i = 1'b0;
  logic                 other_fault_i = 1'b0;
  logic                 output_en_o;
  ivf_pkg::ivf_status_t status_o;
  int                   n_fail = 0;
  int                   n_checks = 0;
  logic [15:0]          rd;
  logic                 er;

  ivf_top ivf_top_inst
  (
    .clk_sys_i      (clk_sys_i),
    .srst_i         (srst_i),
    .cmd_i          (cmd_i),
    .rsp_valid_o    (rsp_valid_o),
    .rsp_err_o      (rsp_err_o),
    .rsp_rdata_o    (rsp_rdata_o),
    .vin_meas_i     (vin_meas_i),
    .unit_tick_i    (unit_tick_i),
    .ctrl_pin_i     (ctrl_pin_i),
    .operation_on_i (operation_on_i),
    .clear_faults_i (clear_faults_i),
    .status_clear_i (status_clear_i),
    .other_fault_i  (other_fault_i),
    .output_en_o    (output_en_o),
    .status_o       (status_o)
  );

  ivf_host_model ivf_host_model_inst
  (
    .clk_sys_i   (clk_sys_i),
    .cmd_o       (cmd_i),
    .rsp_valid_i (rsp_valid_o),
    .rsp_err_i   (rsp_err_o),
    .rsp_rdata_i (rsp_rdata_o)
  );

  initial
  begin
    clk_sys_i = 1'b0;
    forever #5 clk_sys_i = ~clk_sys_i;
  end

  // ****************************************
  // Helpers
  // ****************************************
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_sys_i);
  endtask

  task automatic tick;
    unit_tick_i = 1'b1;
    cyc(1);
    unit_tick_i = 1'b0;
    cyc(2);
  endtask

  task automatic wr(input logic [7:0] c, input logic [15:0] d);
    ivf_host_model_inst.xfer(1'b1, c, d, rd, er);
    cyc(1);
  endtask

  // Policy changes only while healthy: retry count is taken on fault entry
  task automatic fault(input logic [7:0] p);
    wr(8'h5A, {8'h00, p});
    vin_meas_i = 16'h0032;
    cyc(2);
  endtask

  task automatic recover;
    vin_meas_i = 16'h00C8;
    cyc(2);
    status_clear_i = 1'b1;
    cyc(1);
    status_clear_i = 1'b0;
    cyc(3);
    `CHK({output_en_o, status_o.uv_fault}, 2'b10, "no recovery")
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_regs;
    logic [7:0] c[4] = '{8'h57, 8'h58, 8'h59, 8'h5A};
    for (int i = 0; i < 4; i++)
    begin
      ivf_host_model_inst.xfer(1'b1, c[i], 16'hA5C3, rd, er);
      `CHK(rd, 16'h0000, "reset value")
      ivf_host_model_inst.xfer(1'b0, c[i], 16'h0000, rd, er);
      `CHK(rd, (i == 3) ? 16'h00C3 : 16'hA5C3, "readback")
      `CHK(er, 1'b0, "mapped refused")
    end
    ivf_host_model_inst.xfer(1'b1, 8'h33, 16'h1234, rd, er);
    `CHK({er, rd}, {1'b1, 16'h0000}, "unmapped")
    wr(8'h57, 16'h0190);
    wr(8'h58, 16'h0096);
    wr(8'h59, 16'h0064);
    wr(8'h5A, 16'h0000);
    wr(8'hE0, 16'h0000);
    $display("test regs done");
  endtask

  task automatic t_warn;
    vin_meas_i = 16'h01F4;
    cyc(3);
    `CHK({status_o.ov_warn, output_en_o}, 2'b11, "ov warn")
    vin_meas_i = 16'h0082;
    cyc(3);
    `CHK({status_o.uv_warn, status_o.ratio_mode}, 2'b10, "uv warn")
    `CHK(output_en_o, 1'b1, "warn cut output")
    wr(8'hE0, 16'h0001);
    cyc(2);
    `CHK({status_o.ratio_mode, output_en_o}, 2'b11, "ratio on")
    wr(8'hE0, 16'h0000);
    cyc(2);
    `CHK(status_o.ratio_mode, 1'b0, "ratio off")
    fault(8'h00);
    cyc(3);
    `CHK({status_o.uv_fault, output_en_o}, 2'b11, "ignore")
    recover();
    $display("test warn done");
  endtask

  task automatic t_disable;
    for (int n = 0; n < 7; n++)
    begin
      fault({2'b10, n[2:0], 3'b000});
      `CHK(output_en_o, 1'b0, "not disabled")
      repeat (n)
      begin
        `CHK(status_o.latched_off, 1'b0, "early latch")
        tick();
      end
      `CHK(status_o.latched_off, 1'b1, "retries")
      recover();
    end
    $display("test disable done");
  endtask

  task automatic t_delay;
    fault(8'h42);
    repeat (3)
    begin
      tick();
      `CHK({output_en_o, status_o.latched_off}, 2'b10, "delay short")
    end
    tick();
    `CHK({output_en_o, status_o.latched_off}, 2'b01, "delay end")
    recover();
    $display("test delay done");
  endtask

  task automatic t_latch;
    fault(8'hC0);
    vin_meas_i = 16'h00C8;
    cyc(4);
    `CHK({output_en_o, status_o.latched_off}, 2'b01, "latch left")
    ctrl_pin_i = 1'b0;
    cyc(8);
    ctrl_pin_i = 1'b1;
    cyc(8);
    `CHK({output_en_o, status_o.latched_off}, 2'b10, "off-on")
    fault(8'hC0);
    vin_meas_i = 16'h00C8;
    clear_faults_i = 1'b1;
    cyc(1);
    clear_faults_i = 1'b0;
    cyc(3);
    `CHK(output_en_o, 1'b1, "clear faults")
    $display("test latch done");
  endtask

  task automatic t_endless;
    fault(8'hB8);
    repeat (8) tick();
    `CHK({output_en_o, status_o.latched_off}, 2'b00, "endless")
    other_fault_i = 1'b1;
    cyc(2);
    other_fault_i = 1'b0;
    cyc(1);
    `CHK(status_o.latched_off, 1'b1, "other fault")
    recover();
    // Restart succeeds once the input is back at the end of the spacing
    fault(8'hB8);
    vin_meas_i = 16'h00C8;
    tick();
    `CHK({output_en_o, status_o.latched_off}, 2'b10, "restart")
    recover();
    $display("test endless done");
  endtask

  // ****************************************
  // Sequence and verdict
  // ****************************************
  task automatic test_done;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  initial
  begin
    cyc(20);
    srst_i = 1'b0;
    cyc(10);
    t_regs();
    t_warn();
    t_disable();
    t_delay();
    t_latch();
    t_endless();
    test_done();
  end

  // Whole run is a few hundred cycles; this leaves wide margin
  initial
  begin
    #200_000;
    n_fail++;
    test_done();
  end
endmodule
`default_nettype wire
